// File: rtl/osu_pkg.sv
// shared constants and types of the output sync and update control bank
package osu_pkg;

	// avalon-mm slave geometry
	localparam int          ADDR_W        = 12;
	localparam int          DATA_W        = 32;
	localparam int          BE_W          = DATA_W / 8;

	// register indices as printed; the byte address is four times the index
	localparam logic [9:0]  IDX_SYS_CTRL  = 10'h230;
	localparam logic [9:0]  IDX_UPDATE    = 10'h232;
	localparam logic [9:0]  IDX_ACTIVE    = 10'h234;

	localparam logic [ADDR_W-1:0] ADDR_SYS_CTRL = {IDX_SYS_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_UPDATE   = {IDX_UPDATE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_ACTIVE   = {IDX_ACTIVE, 2'b00};

	// system control field positions
	localparam int          SYNC_PD_BIT   = 2;
	localparam int          DIST_PD_BIT   = 1;
	localparam int          SOFT_SYNC_BIT = 0;
	localparam int          SYS_FIELD_W   = 3;

	// update command field position
	localparam int          UPDATE_BIT    = 0;

	// active status register layout (bits above read as zero)
	localparam int          ACT_FIELD_LSB = 0;
	localparam int          ACT_HOLD_BIT  = 3;
	localparam int          ACT_PEND_BIT  = 4;
	localparam int          ACT_PIN_BIT   = 5;

	// reset values
	localparam logic [SYS_FIELD_W-1:0] SYS_CTRL_RST = 3'h0;
	localparam logic                   UPDATE_RST   = 1'b0;

	// avalon response codes
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// number of output channels steered by the sync logic
	localparam int          CHAN_COUNT    = 8;

	typedef struct packed {
		logic syncPd;
		logic distRefPd;
		logic softSync;
	} osu_sys_ctrl_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [DATA_W-1:0] writedata;
		logic [BE_W-1:0]   byteenable;
	} osu_bus_req_t;

endpackage : osu_pkg

// File: rtl/osu_sync_chan.sv
// sync engine: static hold and release trigger for the selected channels
`timescale 1ns/1ps
`default_nettype none

module osu_sync_chan (
	input  wire logic                            ref_clk,
	input  wire logic                            sys_rst,
	input  wire logic                            syncPowerDown,
	input  wire logic                            softSync,
	input  wire logic                            syncPinN,
	input  wire logic [osu_pkg::CHAN_COUNT-1:0]  chanSelect,
	output logic                                 syncAsserted,
	output logic      [osu_pkg::CHAN_COUNT-1:0]  chanHold,
	output logic      [osu_pkg::CHAN_COUNT-1:0]  chanSyncTrigger
);

	logic                           assert_q;
	logic                           assert_d;
	logic [osu_pkg::CHAN_COUNT-1:0] hold_q;
	logic [osu_pkg::CHAN_COUNT-1:0] hold_d;
	logic [osu_pkg::CHAN_COUNT-1:0] trig_q;
	logic [osu_pkg::CHAN_COUNT-1:0] trig_d;
	logic                           release_w;

	// soft bit high acts like the pin low; powered-down sync sees nothing
	always_comb begin
		assert_d  = ~syncPowerDown & (softSync | ~syncPinN);
		release_w = assert_q & ~assert_d;
	end

	genvar gi;
	generate
		for (gi = 0; gi < osu_pkg::CHAN_COUNT; gi++) begin : g_chan
			always_comb begin
				hold_d[gi] = assert_d & chanSelect[gi];
				trig_d[gi] = release_w & chanSelect[gi];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			assert_q <= 1'b0;
			hold_q   <= '0;
			trig_q   <= '0;
		end else begin
			assert_q <= assert_d;
			hold_q   <= hold_d;
			trig_q   <= trig_d;
		end
	end

	assign syncAsserted    = assert_q;
	assign chanHold        = hold_q;
	assign chanSyncTrigger = trig_q;

endmodule : osu_sync_chan

`default_nettype wire

// File: rtl/osu_ctrl_top.sv
// system sync, power-down and update-all register bank on avalon-mm
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module osu_ctrl_top (
	input  wire logic                            ref_clk,
	input  wire logic                            sys_rst,
	input  wire logic [osu_pkg::ADDR_W-1:0]      avs_address,
	input  wire logic                            avs_read,
	input  wire logic                            avs_write,
	input  wire logic [osu_pkg::DATA_W-1:0]      avs_writedata,
	input  wire logic [osu_pkg::BE_W-1:0]        avs_byteenable,
	output logic      [osu_pkg::DATA_W-1:0]      avs_readdata,
	output logic      [1:0]                      avs_response,
	output logic                                 avs_waitrequest,
	input  wire logic                            syncPinN,
	input  wire logic [osu_pkg::CHAN_COUNT-1:0]  chanSelect,
	output logic                                 syncPowerDown,
	output logic                                 distRefPowerDown,
	output logic      [osu_pkg::CHAN_COUNT-1:0]  chanHold,
	output logic      [osu_pkg::CHAN_COUNT-1:0]  chanSyncTrigger,
	output logic                                 updateStrobe
);

	// bus front end

	typedef enum logic {
		BUS_IDLE,
		BUS_ACK
	} osu_bus_state_t;

	osu_bus_state_t               busState_q;
	osu_bus_state_t               busState_d;
	osu_pkg::osu_bus_req_t        req_q;
	osu_pkg::osu_bus_req_t        req_d;
	osu_pkg::osu_bus_req_t        reqLive;
	logic [osu_pkg::DATA_W-1:0]   rdata_q;
	logic [osu_pkg::DATA_W-1:0]   rdata_d;
	logic [1:0]                   resp_q;
	logic [1:0]                   resp_d;

	// address decode of the live request
	logic                         hitSys;
	logic                         hitUpd;
	logic                         hitAct;
	logic                         hitAny;

	// decode of the held request, used when the write commits
	logic                         commitWr;
	logic                         wrSys;
	logic                         wrUpd;

	always_comb begin
		reqLive.address    = avs_address;
		reqLive.read       = avs_read;
		reqLive.write      = avs_write;
		reqLive.writedata  = avs_writedata;
		reqLive.byteenable = avs_byteenable;
	end

	always_comb begin
		hitSys = (avs_address == osu_pkg::ADDR_SYS_CTRL);
		hitUpd = (avs_address == osu_pkg::ADDR_UPDATE);
		hitAct = (avs_address == osu_pkg::ADDR_ACTIVE);
		hitAny = hitSys | hitUpd | hitAct;
	end

	// register state

	// software writes land in buf; hardware only ever acts on act
	osu_pkg::osu_sys_ctrl_t       buf_q;
	osu_pkg::osu_sys_ctrl_t       buf_d;
	osu_pkg::osu_sys_ctrl_t       act_q;
	osu_pkg::osu_sys_ctrl_t       act_d;
	osu_pkg::osu_sys_ctrl_t       sysWrVal;

	// update command: pending flag and the strobe that follows it
	logic                         updSet;
	logic                         updPend_q;
	logic                         updPend_d;
	logic                         updStrobe_q;
	logic                         updStrobe_d;

	// live sync status from the engine, read back on the status register
	logic                         syncAsserted;

	// read words, one per register, and the answer for the live address
	logic [osu_pkg::DATA_W-1:0]   rdSysWord;
	logic [osu_pkg::DATA_W-1:0]   rdUpdWord;
	logic [osu_pkg::DATA_W-1:0]   rdActWord;
	logic [osu_pkg::DATA_W-1:0]   rdWord;
	logic [1:0]                   respLive;

	// bus sequencing: one wait cycle, then the request is answered
	// the read word is captured when the request is taken, so a read shows
	// the state of that edge even if the register moves during the wait

	always_comb begin
		busState_d = busState_q;
		req_d      = req_q;
		rdata_d    = rdata_q;
		resp_d     = resp_q;
		unique case (busState_q)
			BUS_IDLE: begin
				if (avs_read | avs_write) begin
					busState_d = BUS_ACK;
					req_d      = reqLive;
					resp_d     = respLive;
					rdata_d    = '0;
					if (avs_read) begin
						rdata_d = rdWord;
					end
				end
			end
			BUS_ACK: begin
				busState_d = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			busState_q <= BUS_IDLE;
			req_q      <= '0;
			rdata_q    <= '0;
			resp_q     <= osu_pkg::RESP_OKAY;
		end else begin
			busState_q <= busState_d;
			req_q      <= req_d;
			rdata_q    <= rdata_d;
			resp_q     <= resp_d;
		end
	end

	// the request stalls until the acknowledge cycle
	assign avs_waitrequest = (avs_read | avs_write) & (busState_q != BUS_ACK);
	assign avs_readdata    = rdata_q;
	assign avs_response    = resp_q;

	// a write takes effect at the edge that sees waitrequest low;
	// lane 0 carries every field, so a write without it is answered, dropped
	always_comb begin
		commitWr = (busState_q == BUS_ACK) & req_q.write & req_q.byteenable[0];
		wrSys    = commitWr & (req_q.address == osu_pkg::ADDR_SYS_CTRL);
		wrUpd    = commitWr & (req_q.address == osu_pkg::ADDR_UPDATE);
	end

	// readback

	// buffered value reads back on its own address, zero above its fields
	always_comb begin
		rdSysWord                         = '0;
		rdSysWord[osu_pkg::SYNC_PD_BIT]   = buf_q.syncPd;
		rdSysWord[osu_pkg::DIST_PD_BIT]   = buf_q.distRefPd;
		rdSysWord[osu_pkg::SOFT_SYNC_BIT] = buf_q.softSync;
	end

	// the command bit reads as pending until the copy is done
	always_comb begin
		rdUpdWord                      = '0;
		rdUpdWord[osu_pkg::UPDATE_BIT] = updPend_q;
	end

	// active copy plus live sync status, so software can see the result
	always_comb begin
		rdActWord = '0;
		rdActWord[osu_pkg::ACT_FIELD_LSB +: osu_pkg::SYS_FIELD_W] = act_q;
		rdActWord[osu_pkg::ACT_HOLD_BIT] = syncAsserted;
		rdActWord[osu_pkg::ACT_PEND_BIT] = updPend_q;
		rdActWord[osu_pkg::ACT_PIN_BIT]  = syncPinN;
	end

	// unmapped addresses read zero and answer with a slave error
	always_comb begin
		respLive = hitAny ? osu_pkg::RESP_OKAY : osu_pkg::RESP_SLVERR;
		rdWord   = '0;
		if (hitSys) begin
			rdWord = rdSysWord;
		end else if (hitUpd) begin
			rdWord = rdUpdWord;
		end else if (hitAct) begin
			rdWord = rdActWord;
		end
	end

	// buffered system control

	// fields of the held write word, picked from their bit positions
	always_comb begin
		sysWrVal.syncPd    = req_q.writedata[osu_pkg::SYNC_PD_BIT];
		sysWrVal.distRefPd = req_q.writedata[osu_pkg::DIST_PD_BIT];
		sysWrVal.softSync  = req_q.writedata[osu_pkg::SOFT_SYNC_BIT];
	end

	// software writes only the buffer; hardware never sees it directly
	always_comb begin
		buf_d = buf_q;
		if (wrSys) begin
			buf_d = sysWrVal;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			buf_q <= osu_pkg::SYS_CTRL_RST;
		end else begin
			buf_q <= buf_d;
		end
	end

	// update-all command

	// a zero written to the command bit leaves everything alone
	always_comb begin
		updSet = wrUpd & req_q.writedata[osu_pkg::UPDATE_BIT];
	end

	// a new command in the transfer cycle stays pending: set wins
	always_comb begin
		updPend_d = updPend_q;
		if (updPend_q) begin
			updPend_d = 1'b0;
		end
		if (updSet) begin
			updPend_d = 1'b1;
		end
		// the strobe marks the cycle in which the active copy appears
		updStrobe_d = updPend_q;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			updPend_q   <= osu_pkg::UPDATE_RST;
			updStrobe_q <= 1'b0;
		end else begin
			updPend_q   <= updPend_d;
			updStrobe_q <= updStrobe_d;
		end
	end

	assign updateStrobe = updStrobe_q;

	// active system control

	// the copy uses the buffer as it stood before this cycle's write,
	// so a write racing the transfer waits for the next update
	always_comb begin
		act_d = act_q;
		if (updPend_q) begin
			act_d = buf_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			act_q <= osu_pkg::SYS_CTRL_RST;
		end else begin
			act_q <= act_d;
		end
	end

	assign syncPowerDown    = act_q.syncPd;
	assign distRefPowerDown = act_q.distRefPd;

	// sync engine
	// its outputs are registered, so channels lag the active copy one edge

	// pin and soft bit merge here; soft bit 1 equals pin low
	osu_sync_chan u_sync (
		.ref_clk         (ref_clk),
		.sys_rst         (sys_rst),
		.syncPowerDown   (act_q.syncPd),
		.softSync        (act_q.softSync),
		.syncPinN        (syncPinN),
		.chanSelect      (chanSelect),
		.syncAsserted    (syncAsserted),
		.chanHold        (chanHold),
		.chanSyncTrigger (chanSyncTrigger)
	);

endmodule : osu_ctrl_top

`default_nettype wire

// File: bench/osu_ctrl_monitor.sv
// concurrent checks on the ports of the sync and update control bank
`timescale 1ns/1ps
`default_nettype none

module osu_ctrl_monitor (
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic [11:0] avs_address,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	input wire logic        syncPinN,
	input wire logic [7:0]  chanSelect,
	input wire logic        syncPowerDown,
	input wire logic        distRefPowerDown,
	input wire logic [7:0]  chanHold,
	input wire logic [7:0]  chanSyncTrigger,
	input wire logic        updateStrobe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic updHit;
	assign updHit = avs_write && !avs_waitrequest && avs_writedata[0]
		&& avs_byteenable[0] && avs_address == osu_pkg::ADDR_UPDATE;

	a_update_strobe: assert property (updHit |-> ##2 updateStrobe)
		else $error("update write gave no strobe");
	a_strobe_single: assert property (updateStrobe |=> !updateStrobe)
		else $error("update strobe longer than one cycle");
	a_strobe_cause: assert property ($rose(updateStrobe)
		|-> $past(updHit, 2))
		else $error("strobe without an update write");
	a_pd_changes: assert property (
		$changed({syncPowerDown, distRefPowerDown}) |-> $rose(updateStrobe))
		else $error("power-down output moved without update");
	a_pd_gate: assert property (syncPowerDown && $past(syncPowerDown)
		|-> chanHold == 8'h00)
		else $error("channels held while sync powered down");
	a_hold_select: assert property (
		(chanHold & ~$past(chanSelect)) == 8'h00)
		else $error("unselected channel held");
	a_pin_hold: assert property (!syncPinN && !syncPowerDown
		&& $past(!syncPinN) && $past(!syncPowerDown)
		|-> chanHold == $past(chanSelect))
		else $error("low sync pin did not hold channels");
	a_trig_release: assert property (chanSyncTrigger != 8'h00
		|-> (chanSyncTrigger & (chanHold | ~$past(chanHold))) == 8'h00)
		else $error("trigger not on release of hold");
endmodule : osu_ctrl_monitor

bind osu_ctrl_top osu_ctrl_monitor osu_ctrl_monitor_inst (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .avs_address(avs_address), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest), .syncPinN(syncPinN),
	.chanSelect(chanSelect), .syncPowerDown(syncPowerDown),
	.distRefPowerDown(distRefPowerDown), .chanHold(chanHold),
	.chanSyncTrigger(chanSyncTrigger), .updateStrobe(updateStrobe));
`default_nettype wire

// File: bench/tb.sv
// self-checking bench of the sync and update control bank
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [11:0] avs_address = 12'h000;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic [1:0]  avs_response;
	logic        avs_waitrequest;
	logic        syncPinN = 1'b1;
	logic [7:0]  chanSelect = 8'ha5;
	logic        syncPowerDown;
	logic        distRefPowerDown;
	logic [7:0]  chanHold;
	logic [7:0]  chanSyncTrigger;
	logic        updateStrobe;
	logic [31:0] rd;
	logic [1:0]  rs;
	logic [7:0]  trig;
	int          strb = 0;
	int          errors = 0;
	int          cmp_count = 0;
	int          cycles = 0;

	osu_ctrl_top osu_ctrl_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
		.syncPinN(syncPinN), .chanSelect(chanSelect),
		.syncPowerDown(syncPowerDown), .distRefPowerDown(distRefPowerDown),
		.chanHold(chanHold), .chanSyncTrigger(chanSyncTrigger),
		.updateStrobe(updateStrobe));

	always #2.5 ref_clk = ~ref_clk;

	task automatic results;
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	// cuts a hung handshake short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			results();
		end
	end

	task automatic chk(input string n, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	// request stands until a rising edge samples waitrequest low
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		rs = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	// buffered value, then the update command, then collect triggers
	task automatic upd(input logic [2:0] v);
		bus(1'b1, osu_pkg::ADDR_SYS_CTRL, {29'h0, v});
		bus(1'b1, osu_pkg::ADDR_UPDATE, 32'h1);
		trig = 8'h00;
		repeat (6) @(negedge ref_clk) trig |= chanSyncTrigger;
	endtask : upd

	task automatic t_regs;
		bus(1'b0, osu_pkg::ADDR_SYS_CTRL, 32'h0);
		chk("sys_rst_val", rd, 32'h0);
		bus(1'b0, 12'h004, 32'h0);
		chk("unmapped_resp", {30'h0, rs}, {30'h0, osu_pkg::RESP_SLVERR});
		bus(1'b1, osu_pkg::ADDR_SYS_CTRL, 32'h6);
		bus(1'b1, osu_pkg::ADDR_UPDATE, 32'h0);
		strb = 0;
		repeat (4) @(negedge ref_clk) strb += updateStrobe;
		chk("pd_before_upd", {syncPowerDown, distRefPowerDown}, 2'b00);
		chk("no_strobe", strb, 32'h0);
		bus(1'b1, osu_pkg::ADDR_UPDATE, 32'h1);
		strb = 0;
		repeat (4) @(negedge ref_clk) strb += updateStrobe;
		chk("sync_pd", syncPowerDown, 1'b1);
		chk("dist_pd", distRefPowerDown, 1'b1);
		chk("upd_strobe", strb, 32'h1);
		bus(1'b0, osu_pkg::ADDR_ACTIVE, 32'h0);
		chk("act_readback", rd, 32'h26);
		bus(1'b0, osu_pkg::ADDR_UPDATE, 32'h0);
		chk("upd_self_clear", rd, 32'h0);
	endtask : t_regs

	task automatic t_pin;
		@(posedge ref_clk) syncPinN <= 1'b0;
		repeat (4) @(negedge ref_clk);
		chk("hold_pd", chanHold, 8'h00);
		upd(3'h0);
		chk("pd_off", syncPowerDown, 1'b0);
		chk("pin_hold", chanHold, chanSelect);
		@(posedge ref_clk) syncPinN <= 1'b1;
		trig = 8'h00;
		repeat (6) @(negedge ref_clk) trig |= chanSyncTrigger;
		chk("pin_trig", trig, chanSelect);
	endtask : t_pin

	task automatic t_soft;
		upd(3'h1);
		chk("soft_hold", chanHold, chanSelect);
		chk("soft_no_trig", trig, 8'h00);
		upd(3'h0);
		chk("soft_trig", trig, chanSelect);
		chk("soft_free", chanHold, 8'h00);
	endtask : t_soft

	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_pin();
		t_soft();
		results();
	end
endmodule : tb
`default_nettype wire
